// [src/ext_err_cfg.svh]
// Constants for the external-interface error capture block.
// Assumes a 25 MHz core clock and a plain register port with one-cycle read data.
`ifndef EXT_ERR_CFG_SVH
`define EXT_ERR_CFG_SVH
`define EE_ADDR_W 4
`define EE_OFF_STATUS 4'h0
`define EE_OFF_ADDRESS_LO 4'h1
`define EE_OFF_ADDRESS_HI 4'h2
`define EE_OFF_SYNDROME 4'h3
`define EE_OFF_TAG_PROBE 4'h4
`define EE_OFF_FETCH_CTL 4'h5
`define EE_OFF_INT_SUMMARY 4'h6
`define EE_OFF_ICACHE_ERR 4'h7
`define EE_OFF_DCACHE_ERR 4'h8
`define EE_OFF_L2_STATUS 4'h9
`define EE_OFF_L2_ADDRESS 4'ha
`define EE_OFF_ARITH_SUM 4'hb
`define EE_OFF_ARITH_MASK 4'hc
`define EE_OFF_INT_CLEAR 4'hd
`define EE_ST_UNCORRECTABLE 0
`define EE_ST_SECOND 1
`define EE_ST_SOURCE 2
`define EE_ST_FILL_INSTR 3
`define EE_ST_TAG_PAR 4
`define EE_ST_TAG_CTL_PAR 5
`define EE_ST_CMD_PAR 6
`define EE_ST_CORRECTABLE 7
`define EE_ST_LOCKED 8
`define EE_FC_CORR_INT_EN 0
`define EE_FC_FIRMWARE_MODE 1
`define EE_FC_PARITY_MODE 2
`define EE_IS_CORR_PEND 0
`define EE_IS_SYS_PEND 1
`define EE_IC_TIMEOUT 11
`define EE_IC_LOCK 12
`define EE_ICACHE_UNLOCK 32'h0000_1800
`define EE_DCACHE_UNLOCK 32'h0000_0003
`define EE_DC_LOCK 1
`define EE_RESET_WORD 32'h0000_0000
`define EE_PARTIAL_RESET_CYCLES 4'h4
`endif

// [src/ext_err_pkg.sv]
// Types shared by the external-interface error capture block.
// Assumes ext_err_cfg.svh for numeric layout.
package ext_err_pkg;
    typedef enum logic [2:0] {
        EV_NONE = 3'b000,
        EV_UNCORRECTABLE = 3'b001,
        EV_CORRECTABLE = 3'b010,
        EV_TAG_PARITY = 3'b011,
        EV_TAG_CTL_PARITY = 3'b100,
        EV_CMD_PARITY = 3'b101
    } err_kind_t;
    typedef struct packed {
        err_kind_t kind;
        logic from_system;
        logic instr_fill;
        logic cache_enabled;
        logic [35:0] addr;
        logic [15:0] syndrome;
        logic [15:0] byte_parity;
        logic [31:0] tag_probe;
    } err_report_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef enum logic [1:0] {
        PR_IDLE = 2'b00,
        PR_ACTIVE = 2'b01
    } preset_state_t;
endpackage

// [src/error_event_sorter.sv]
// Reduces the fill, tag and command error strobes to one report per cycle.
// Assumes all strobes come from logic on clk_in; in parity mode the byte status replaces the syndrome.
`timescale 1ns/1ps
`default_nettype none
`include "ext_err_cfg.svh"
module error_event_sorter (
    input wire logic fill_unc_in,
    input wire logic fill_cor_in,
    input wire logic tag_par_in,
    input wire logic tag_ctl_par_in,
    input wire logic cmd_par_in,
    input wire logic parity_mode_in,
    input wire ext_err_pkg::err_report_t raw_in,
    output ext_err_pkg::err_report_t report_out,
    output logic multi_out
);
    logic [4:0] hits;
    always_comb begin
        hits = {fill_unc_in, fill_cor_in, tag_par_in, tag_ctl_par_in, cmd_par_in};
        multi_out = (hits & (hits - 5'h01)) != 5'h00;
        report_out = raw_in;
        if (parity_mode_in) begin
            report_out.syndrome = raw_in.byte_parity;
        end
        if (fill_unc_in) begin
            report_out.kind = ext_err_pkg::EV_UNCORRECTABLE;
        end else if (tag_par_in) begin
            report_out.kind = ext_err_pkg::EV_TAG_PARITY;
            report_out.from_system = 1'b0;
        end else if (tag_ctl_par_in) begin
            report_out.kind = ext_err_pkg::EV_TAG_CTL_PARITY;
            report_out.from_system = 1'b0;
        end else if (cmd_par_in) begin
            report_out.kind = ext_err_pkg::EV_CMD_PARITY;
            report_out.from_system = 1'b1;
        end else if (fill_cor_in) begin
            report_out.kind = ext_err_pkg::EV_CORRECTABLE;
        end else begin
            report_out.kind = ext_err_pkg::EV_NONE;
        end
    end
endmodule
`default_nettype wire

// [src/sys_signal_sync.sv]
// Two-flop synchronisers for the pins that arrive from the system bus.
// Assumes the pins are asynchronous to clk_in; stage one feeds stage two only.
`timescale 1ns/1ps
`default_nettype none
module sys_signal_sync #(
    parameter int WIDTH = 6
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_r;
    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be at least one");
    end
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk_in) begin
            if (reset_in) begin
                stage1_r[i] <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                stage1_r[i] <= async_in[i];
                sync_out[i] <= stage1_r[i];
            end
        end
    end
endmodule
`default_nettype wire

// [src/external_error_capture_machine_check_trap.sv]
// Error capture and machine-check logic for the external cache and system bus interface.
// Assumes error strobes from the fill and tag logic on clk_in; system pins arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "ext_err_cfg.svh"
module external_error_capture_machine_check_trap (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire ext_err_pkg::reg_req_t req_in,
    output logic [31:0] rdata_out,
    input wire logic fill_unc_in,
    input wire logic fill_cor_in,
    input wire logic tag_par_in,
    input wire logic tag_ctl_par_in,
    input wire logic cmd_par_in,
    input wire ext_err_pkg::err_report_t raw_in,
    input wire logic tag_match_in,
    input wire logic tag_dirty_in,
    input wire logic cache_read_out_in,
    input wire logic [127:0] cache_data_in,
    input wire logic fetch_timer_expired_in,
    input wire logic interrupt_level31_in,
    input wire logic l2_error_in,
    input wire logic [31:0] l2_status_in,
    input wire logic [35:0] l2_address_in,
    input wire logic icache_error_in,
    input wire logic dcache_error_in,
    input wire logic arith_event_in,
    input wire logic [31:0] arith_bits_in,
    input wire logic fill_fault_pin_in,
    input wire logic system_check_pin_in,
    input wire logic cmd_fail_pin_in,
    input wire logic cmd_ack_pin_in,
    input wire logic sysclk_edge_pin_in,
    input wire logic valid_cmd_pin_in,
    output logic machine_check_trap_out,
    output logic correctable_int_out,
    output logic system_check_int_out,
    output logic negative_acknowledge_out,
    output logic partial_reset_out,
    output logic dcache_invalidate_out,
    output logic cache_hit_out,
    output logic victim_writeback_out,
    output logic [127:0] sys_data_out
);
    logic [4:0] pins_sync;
    ext_err_pkg::err_report_t report;
    logic multi;
    logic [8:0] status_r;
    logic [35:0] address_r;
    logic [15:0] syndrome_r;
    logic [31:0] tag_probe_r;
    logic [2:0] fetch_ctl_r;
    logic [1:0] int_summary_r;
    logic [12:0] icache_err_r;
    logic [1:0] dcache_err_r;
    logic [31:0] l2_status_r;
    logic [35:0] l2_address_r;
    logic l2_locked_r;
    logic [31:0] arith_sum_r;
    logic [31:0] arith_mask_r;
    logic arith_locked_r;
    logic prev_nop_err_r;
    logic [3:0] preset_cnt_r;
    ext_err_pkg::preset_state_t preset_state_r;
    logic any_error;
    logic hard_error;
    logic locked;
    logic timeout_event;
    logic cmd_fail_event;
    logic wr_hit;
    logic rd_hit;

    sys_signal_sync #(
        .WIDTH(5)
    ) u_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .async_in({fill_fault_pin_in, system_check_pin_in, cmd_fail_pin_in, cmd_ack_pin_in,
            sysclk_edge_pin_in}),
        .sync_out(pins_sync)
    );

    error_event_sorter u_sort (
        .fill_unc_in(fill_unc_in),
        .fill_cor_in(fill_cor_in),
        .tag_par_in(tag_par_in),
        .tag_ctl_par_in(tag_ctl_par_in),
        .cmd_par_in(cmd_par_in),
        .parity_mode_in(fetch_ctl_r[`EE_FC_PARITY_MODE]),
        .raw_in(raw_in),
        .report_out(report),
        .multi_out(multi)
    );

    // A command fail only counts in a sysclk cycle that carries no acknowledge.
    assign cmd_fail_event = pins_sync[0] && pins_sync[2] && !pins_sync[1];
    assign timeout_event = fetch_timer_expired_in || cmd_fail_event;
    assign any_error = report.kind != ext_err_pkg::EV_NONE;
    assign hard_error = any_error && report.kind != ext_err_pkg::EV_CORRECTABLE;
    // A status read in the same cycle as a new error unlocks first, so that error is captured fresh.
    assign locked = status_r[`EE_ST_LOCKED] && !(rd_hit && req_in.addr == `EE_OFF_STATUS);
    assign wr_hit = req_in.wr;
    assign rd_hit = req_in.rd;

    // Capture state: only the first error is kept, so firmware sees the root cause.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            status_r <= 9'h000;
            address_r <= 36'h0_0000_0000;
            syndrome_r <= 16'h0000;
            tag_probe_r <= `EE_RESET_WORD;
        end else begin
            if (rd_hit && req_in.addr == `EE_OFF_STATUS) begin
                status_r <= 9'h000;
            end
            if (any_error && locked) begin
                status_r[`EE_ST_SECOND] <= 1'b1;
            end else if (any_error) begin
                status_r <= 9'h000;
                status_r[`EE_ST_LOCKED] <= 1'b1;
                status_r[`EE_ST_SECOND] <= multi;
                status_r[`EE_ST_UNCORRECTABLE] <= report.kind == ext_err_pkg::EV_UNCORRECTABLE;
                status_r[`EE_ST_CORRECTABLE] <= report.kind == ext_err_pkg::EV_CORRECTABLE;
                status_r[`EE_ST_TAG_PAR] <= report.kind == ext_err_pkg::EV_TAG_PARITY;
                status_r[`EE_ST_TAG_CTL_PAR] <= report.kind == ext_err_pkg::EV_TAG_CTL_PARITY;
                status_r[`EE_ST_CMD_PAR] <= report.kind == ext_err_pkg::EV_CMD_PARITY;
                status_r[`EE_ST_SOURCE] <= report.from_system;
                status_r[`EE_ST_FILL_INSTR] <= report.instr_fill;
                address_r <= report.addr;
                syndrome_r <= report.syndrome;
                if (report.kind != ext_err_pkg::EV_CORRECTABLE && report.cache_enabled) begin
                    tag_probe_r <= report.tag_probe;
                end
            end
        end
    end

    // Trap and acknowledge outputs; fill fault traps but leaves no status behind.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            machine_check_trap_out <= 1'b0;
            negative_acknowledge_out <= 1'b0;
            prev_nop_err_r <= 1'b0;
            dcache_invalidate_out <= 1'b0;
        end else begin
            machine_check_trap_out <= hard_error || pins_sync[4] || timeout_event;
            // An errored NOP followed by a valid command draws a negative acknowledge for that command too.
            negative_acknowledge_out <= cmd_par_in || (prev_nop_err_r && valid_cmd_pin_in);
            prev_nop_err_r <= cmd_par_in && !valid_cmd_pin_in;
            dcache_invalidate_out <= report.kind == ext_err_pkg::EV_CORRECTABLE;
        end
    end

    // The fill data path itself corrects single-bit errors; this block only registers hit, victim and outgoing cache data.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cache_hit_out <= 1'b0;
            victim_writeback_out <= 1'b0;
            sys_data_out <= 128'h0;
        end else begin
            cache_hit_out <= tag_match_in;
            victim_writeback_out <= tag_dirty_in;
            if (cache_read_out_in) begin
                sys_data_out <= cache_data_in;
            end
        end
    end

    // Interrupt summary and gating.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            int_summary_r <= 2'b00;
            correctable_int_out <= 1'b0;
            system_check_int_out <= 1'b0;
        end else begin
            if (wr_hit && req_in.addr == `EE_OFF_INT_CLEAR) begin
                int_summary_r <= int_summary_r & ~req_in.wdata[1:0];
            end
            if (report.kind == ext_err_pkg::EV_CORRECTABLE) begin
                int_summary_r[`EE_IS_CORR_PEND] <= 1'b1;
            end
            if (pins_sync[3]) begin
                int_summary_r[`EE_IS_SYS_PEND] <= 1'b1;
            end
            correctable_int_out <= int_summary_r[`EE_IS_CORR_PEND] &&
                fetch_ctl_r[`EE_FC_CORR_INT_EN];
            system_check_int_out <= int_summary_r[`EE_IS_SYS_PEND] && !interrupt_level31_in &&
                !fetch_ctl_r[`EE_FC_FIRMWARE_MODE];
        end
    end

    // Partial reset pulse; internal registers are untouched by it.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            preset_state_r <= ext_err_pkg::PR_IDLE;
            preset_cnt_r <= 4'h0;
            partial_reset_out <= 1'b0;
        end else begin
            case (preset_state_r)
                ext_err_pkg::PR_IDLE: begin
                    if (timeout_event) begin
                        preset_state_r <= ext_err_pkg::PR_ACTIVE;
                        preset_cnt_r <= `EE_PARTIAL_RESET_CYCLES;
                        partial_reset_out <= 1'b1;
                    end
                end
                ext_err_pkg::PR_ACTIVE: begin
                    preset_cnt_r <= preset_cnt_r - 4'h1;
                    if (preset_cnt_r == 4'h1) begin
                        preset_state_r <= ext_err_pkg::PR_IDLE;
                        partial_reset_out <= 1'b0;
                    end
                end
                default: begin
                    preset_state_r <= ext_err_pkg::PR_IDLE;
                    partial_reset_out <= 1'b0;
                end
            endcase
        end
    end

    // Cache error status registers with their unlock writes.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            icache_err_r <= 13'h0000;
            dcache_err_r <= 2'b00;
            fetch_ctl_r <= 3'b000;
        end else begin
            if (wr_hit && req_in.addr == `EE_OFF_FETCH_CTL) begin
                fetch_ctl_r <= req_in.wdata[2:0];
            end
            if (wr_hit && req_in.addr == `EE_OFF_ICACHE_ERR && req_in.wdata == `EE_ICACHE_UNLOCK) begin
                icache_err_r <= 13'h0000;
            end
            if (wr_hit && req_in.addr == `EE_OFF_DCACHE_ERR && req_in.wdata == `EE_DCACHE_UNLOCK) begin
                dcache_err_r <= 2'b00;
            end
            if (icache_error_in) begin
                icache_err_r[`EE_IC_LOCK] <= 1'b1;
            end
            if (timeout_event) begin
                icache_err_r[`EE_IC_TIMEOUT] <= 1'b1;
            end
            if (dcache_error_in) begin
                dcache_err_r[`EE_DC_LOCK] <= 1'b1;
            end
        end
    end

    // Second-level cache and arithmetic exception registers.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            l2_status_r <= `EE_RESET_WORD;
            l2_address_r <= 36'h0_0000_0000;
            l2_locked_r <= 1'b0;
            arith_sum_r <= `EE_RESET_WORD;
            arith_mask_r <= `EE_RESET_WORD;
            arith_locked_r <= 1'b0;
        end else begin
            if (rd_hit && req_in.addr == `EE_OFF_L2_STATUS) begin
                l2_locked_r <= 1'b0;
            end
            if (l2_error_in && !l2_locked_r) begin
                l2_status_r <= l2_status_in;
                l2_address_r <= l2_address_in;
                l2_locked_r <= 1'b1;
            end
            if (wr_hit && req_in.addr == `EE_OFF_ARITH_SUM) begin
                arith_sum_r <= `EE_RESET_WORD;
                arith_locked_r <= 1'b0;
            end
            if (arith_event_in) begin
                arith_sum_r <= arith_sum_r | arith_bits_in;
                if (!arith_locked_r) begin
                    arith_mask_r <= arith_bits_in;
                    arith_locked_r <= 1'b1;
                end
            end
        end
    end

    // Read port: data stand in the cycle after the strobe only.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_out <= `EE_RESET_WORD;
        end else if (rd_hit) begin
            case (req_in.addr)
                `EE_OFF_STATUS: rdata_out <= {23'h0, status_r};
                `EE_OFF_ADDRESS_LO: rdata_out <= {address_r[27:0], 4'h0};
                `EE_OFF_ADDRESS_HI: rdata_out <= {24'h0, address_r[35:28]};
                `EE_OFF_SYNDROME: rdata_out <= {16'h0, syndrome_r};
                `EE_OFF_TAG_PROBE: rdata_out <= tag_probe_r;
                `EE_OFF_FETCH_CTL: rdata_out <= {29'h0, fetch_ctl_r};
                `EE_OFF_INT_SUMMARY: rdata_out <= {30'h0, int_summary_r};
                `EE_OFF_ICACHE_ERR: rdata_out <= {19'h0, icache_err_r};
                `EE_OFF_DCACHE_ERR: rdata_out <= {30'h0, dcache_err_r};
                `EE_OFF_L2_STATUS: rdata_out <= l2_status_r;
                `EE_OFF_L2_ADDRESS: rdata_out <= {l2_address_r[27:0], 4'h0};
                `EE_OFF_ARITH_SUM: rdata_out <= arith_sum_r;
                `EE_OFF_ARITH_MASK: rdata_out <= arith_mask_r;
                default: rdata_out <= `EE_RESET_WORD;
            endcase
        end else begin
            rdata_out <= `EE_RESET_WORD;
        end
    end
endmodule
`default_nettype wire

// [test/sys_bus_partner.sv]
// Model of the system bus side that drives the system pins at a sysclk ratio of 3.
// Assumes the bench selects the action on op_in and holds it for as long as it wants it.
`timescale 1ns/1ps
`default_nettype none
module sys_bus_partner (
    input wire logic clk_in,
    input wire logic [1:0] op_in,
    output logic fill_fault_out,
    output logic system_check_out,
    output logic cmd_fail_out,
    output logic cmd_ack_out,
    output logic sysclk_edge_out
);
    logic [1:0] phase_r = 2'h0;
    always_ff @(posedge clk_in) begin
        phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
    end
    // The fault lasts while op_in selects it; the fill sequence beside it is not modelled.
    assign fill_fault_out = (op_in == 2'h1);
    assign system_check_out = (op_in == 2'h3);
    assign cmd_fail_out = (op_in == 2'h2) && (phase_r == 2'h0);
    assign cmd_ack_out = 1'b0;
    assign sysclk_edge_out = (phase_r == 2'h0);
endmodule
`default_nettype wire

// [test/ext_err_assertions.sv]
// Checker for the external error capture block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ext_err_checker (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic fill_unc_in,
    input wire logic fill_cor_in,
    input wire logic tag_par_in,
    input wire logic tag_ctl_par_in,
    input wire logic cmd_par_in,
    input wire logic cache_read_out_in,
    input wire logic [127:0] cache_data_in,
    input wire logic fetch_timer_expired_in,
    input wire logic cmd_fail_pin_in,
    input wire logic cmd_ack_pin_in,
    input wire logic sysclk_edge_pin_in,
    input wire logic fill_fault_pin_in,
    input wire logic tag_match_in,
    input wire logic tag_dirty_in,
    input wire logic cache_hit_out,
    input wire logic victim_writeback_out,
    input wire logic machine_check_trap_out,
    input wire logic negative_acknowledge_out,
    input wire logic partial_reset_out,
    input wire logic dcache_invalidate_out,
    input wire logic [127:0] sys_data_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_fail_no_ack;
        sysclk_edge_pin_in && cmd_fail_pin_in && !cmd_ack_pin_in;
    endsequence
    sequence s_preset_run;
        partial_reset_out [*4] ##1 !partial_reset_out;
    endsequence
    property p_unc_trap;
        fill_unc_in |=> machine_check_trap_out;
    endproperty
    a_unc_trap: assert property (p_unc_trap) else $error("no trap after fill error");
    property p_tag_trap;
        (tag_par_in || tag_ctl_par_in) |=> machine_check_trap_out;
    endproperty
    a_tag_trap: assert property (p_tag_trap) else $error("no trap after tag error");
    property p_cmd_nack;
        cmd_par_in |=> negative_acknowledge_out;
    endproperty
    a_cmd_nack: assert property (p_cmd_nack) else $error("command not refused");
    property p_cor_inval;
        fill_cor_in |=> dcache_invalidate_out;
    endproperty
    a_cor_inval: assert property (p_cor_inval) else $error("data cache not invalidated");
    property p_timer;
        fetch_timer_expired_in |=> machine_check_trap_out && partial_reset_out;
    endproperty
    a_timer: assert property (p_timer) else $error("timer expiry ignored");
    property p_preset_len;
        $rose(partial_reset_out) |-> s_preset_run;
    endproperty
    a_preset_len: assert property (p_preset_len) else $error("partial reset length wrong");
    property p_cfail;
        s_fail_no_ack |-> ##[1:4] (partial_reset_out && machine_check_trap_out);
    endproperty
    a_cfail: assert property (p_cfail) else $error("command fail ignored");
    property p_sysdata;
        cache_read_out_in |=> sys_data_out == $past(cache_data_in);
    endproperty
    a_sysdata: assert property (p_sysdata) else $error("outgoing cache data altered");
    property p_fault_trap;
        fill_fault_pin_in |-> ##3 machine_check_trap_out;
    endproperty
    a_fault_trap: assert property (p_fault_trap) else $error("no trap after fill fault");
    property p_hit_victim;
        !$past(reset_in) |-> cache_hit_out == $past(tag_match_in) &&
            victim_writeback_out == $past(tag_dirty_in);
    endproperty
    a_hit_victim: assert property (p_hit_victim) else $error("hit or victim not from tag");
endmodule
bind external_error_capture_machine_check_trap ext_err_checker chk (.*);
`default_nettype wire

// [test/external_error_capture_machine_check_trap_tb_top.sv]
// Self-checking bench for the external error capture block.
// Assumes the partner model drives the system pins and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "ext_err_cfg.svh"
module external_error_capture_machine_check_trap_tb_top;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    ext_err_pkg::reg_req_t req = '0;
    ext_err_pkg::err_report_t raw = '0;
    ext_err_pkg::err_report_t ra;
    logic [4:0] ev = '0;
    logic [4:0] pl = '0;
    logic [1:0] op = '0;
    logic tm = 1'b0, td = 1'b0, cro = 1'b0, l31 = 1'b0, rd_seen = 1'b0;
    logic [127:0] cd = '0;
    logic [127:0] sd;
    logic [31:0] rdata_out, ab = '0, l2s = '0;
    logic [35:0] l2a = '0;
    logic [63:0] ent;
    logic [63:0] q[$];
    localparam logic [24:0] kinds = 25'h0282081;
    localparam logic [59:0] stexp = 60'h18c_144_120_118_101;
    logic mc, ci, sci, nk, pr, di, ch, vw, ff, sc, cf, ck, se;
    int num_errors = 0;
    int total_checks = 0;
    sys_bus_partner bus (.clk_in(clk_in), .op_in(op), .fill_fault_out(ff), .system_check_out(sc),
        .cmd_fail_out(cf), .cmd_ack_out(ck), .sysclk_edge_out(se));
    external_error_capture_machine_check_trap uut (.clk_in(clk_in), .reset_in(reset_in), .req_in(req), .rdata_out(rdata_out),
        .fill_unc_in(ev[0]), .fill_cor_in(ev[1]), .tag_par_in(ev[2]), .tag_ctl_par_in(ev[3]), .cmd_par_in(ev[4]),
        .raw_in(raw), .tag_match_in(tm), .tag_dirty_in(td), .cache_read_out_in(cro), .cache_data_in(cd),
        .fetch_timer_expired_in(pl[0]), .interrupt_level31_in(l31), .l2_error_in(pl[4]), .l2_status_in(l2s),
        .l2_address_in(l2a), .icache_error_in(pl[1]), .dcache_error_in(pl[2]), .arith_event_in(pl[3]),
        .arith_bits_in(ab), .fill_fault_pin_in(ff), .system_check_pin_in(sc), .cmd_fail_pin_in(cf),
        .cmd_ack_pin_in(ck), .sysclk_edge_pin_in(se), .valid_cmd_pin_in(1'b0), .machine_check_trap_out(mc),
        .correctable_int_out(ci), .system_check_int_out(sci), .negative_acknowledge_out(nk),
        .partial_reset_out(pr), .dcache_invalidate_out(di), .cache_hit_out(ch), .victim_writeback_out(vw),
        .sys_data_out(sd));
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cd <= {$urandom(), $urandom(), $urandom(), $urandom()};
        {cro, tm, td} <= 3'($urandom());
        rd_seen <= req.rd;
    end
    always @(negedge clk_in) begin
        if (rd_seen) begin
            ent = q.pop_front();
            cmp(rdata_out & ent[63:32], ent[31:0]);
        end
    end
    task automatic cmp(logic [31:0] got, logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t read got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_lvl(logic sel, logic exp);
        logic got;
        req <= '0;
        @(negedge clk_in);
        got = sel ? sci : ci;
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t output level got %b", $time, got);
        end
        @(posedge clk_in);
    endtask
    task automatic tick(int n);
        req <= '0;
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] e, logic [31:0] m = 32'hffff_ffff);
        q.push_back({m, e & m});
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
    endtask
    task automatic err(logic [4:0] k, ext_err_pkg::err_report_t r);
        ev <= k;
        raw <= r;
        tick(1);
        ev <= '0;
        @(posedge clk_in);
    endtask
    task automatic pls(int b);
        pl <= 5'(1 << b);
        tick(1);
        pl <= '0;
    endtask
    function automatic ext_err_pkg::err_report_t mk(logic s, logic i);
        mk = '0;
        mk.from_system = s;
        mk.instr_fill = i;
        mk.cache_enabled = 1'b1;
        mk.addr = 36'({$urandom(), $urandom()});
        mk.syndrome = 16'($urandom());
        mk.byte_parity = 16'($urandom());
        mk.tag_probe = $urandom();
    endfunction
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #(40ns * 20000);
        num_errors++;
        report_and_stop();
    end
    initial begin
        void'($urandom(83));
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(`EE_OFF_STATUS, 32'h0);
        wr(`EE_OFF_FETCH_CTL, 32'h5);
        ra = mk(1'b1, 1'b1);
        err(5'h01, ra);
        err(5'h01, mk(1'b0, 1'b0));
        rd(`EE_OFF_ADDRESS_LO, {ra.addr[27:0], 4'h0});
        rd(`EE_OFF_ADDRESS_HI, {24'h0, ra.addr[35:28]}, 32'hff);
        rd(`EE_OFF_SYNDROME, {16'h0, ra.byte_parity}, 32'hffff);
        rd(`EE_OFF_TAG_PROBE, ra.tag_probe);
        rd(`EE_OFF_STATUS, 32'h10f, 32'h1ff);
        rd(`EE_OFF_STATUS, 32'h0, 32'h1ff);
        // Cases: uncorrectable, tag, tag control, command, correctable.
        for (int k = 0; k < 5; k++) begin
            err(kinds[k*5 +: 5], mk(k == 1 || k == 4, k == 1 || k == 4));
            rd(`EE_OFF_STATUS, {20'h0, stexp[k*12 +: 12]}, 32'h1ff);
        end
        chk_lvl(1'b0, 1'b1);
        rd(`EE_OFF_INT_SUMMARY, 32'h1, 32'h1);
        wr(`EE_OFF_INT_CLEAR, 32'h1);
        wr(`EE_OFF_FETCH_CTL, 32'h0);
        err(5'h02, mk(1'b0, 1'b0));
        chk_lvl(1'b0, 1'b0);
        rd(`EE_OFF_STATUS, 32'h180, 32'h180);
        op <= 2'h3;
        tick(6);
        chk_lvl(1'b1, 1'b1);
        rd(`EE_OFF_INT_SUMMARY, 32'h2, 32'h2);
        l31 <= 1'b1;
        tick(2);
        chk_lvl(1'b1, 1'b0);
        l31 <= 1'b0;
        wr(`EE_OFF_FETCH_CTL, 32'h2);
        tick(2);
        chk_lvl(1'b1, 1'b0);
        op <= 2'h1;
        tick(1);
        op <= 2'h0;
        wr(`EE_OFF_FETCH_CTL, 32'h0);
        tick(5);
        rd(`EE_OFF_STATUS, 32'h0, 32'h1ff);
        pls(0);
        rd(`EE_OFF_ICACHE_ERR, 32'h800, 32'h800);
        wr(`EE_OFF_ICACHE_ERR, `EE_ICACHE_UNLOCK);
        op <= 2'h2;
        tick(3);
        op <= 2'h0;
        tick(8);
        rd(`EE_OFF_ICACHE_ERR, 32'h800, 32'h800);
        pls(1);
        wr(`EE_OFF_ICACHE_ERR, 32'h1234);
        rd(`EE_OFF_ICACHE_ERR, 32'h1000, 32'h1000);
        wr(`EE_OFF_ICACHE_ERR, `EE_ICACHE_UNLOCK);
        rd(`EE_OFF_ICACHE_ERR, 32'h0, 32'h1000);
        pls(2);
        wr(`EE_OFF_DCACHE_ERR, 32'h1);
        rd(`EE_OFF_DCACHE_ERR, 32'h2, 32'h2);
        wr(`EE_OFF_DCACHE_ERR, `EE_DCACHE_UNLOCK);
        rd(`EE_OFF_DCACHE_ERR, 32'h0, 32'h2);
        ab <= $urandom();
        l2s <= $urandom();
        pls(3);
        rd(`EE_OFF_ARITH_SUM, ab);
        wr(`EE_OFF_ARITH_SUM, 32'h0);
        rd(`EE_OFF_ARITH_SUM, 32'h0);
        pls(4);
        rd(`EE_OFF_L2_STATUS, l2s);
        rd(4'hf, 32'h0);
        tick(3);
        report_and_stop();
    end
endmodule
`default_nettype wire
